// ---- src/servo_follow_pkg.sv ----
// Constants shared by the servo torque, velocity limit and follow block.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
package servo_follow_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_US = 120;
  localparam int TICK_CYCLES = (TICK_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [15:0] FULL_CURRENT = 16'h4e20;
  localparam logic [15:0] MIN_MOTION_VLIM = 16'h01c7;
  localparam logic [15:0] MODE_ABSOLUTE = 16'h0000;
  localparam logic [15:0] RST_VLIM = 16'h7fff;
  localparam logic [15:0] RST_RAMP_INC = 16'h0001;
  localparam logic [7:0] RST_CYCLES = 8'h01;
  localparam logic [7:0] ADDR_RAMP = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_VLIM = 8'h0c;
  localparam logic [7:0] ADDR_FOLLOW = 8'h10;
  localparam logic [7:0] ADDR_SETTLE = 8'h14;
  localparam logic [7:0] ADDR_TRAJ_VEL = 8'h18;
  localparam logic [7:0] ADDR_GRAVITY = 8'h1c;
  localparam logic [7:0] ADDR_ACCEL = 8'h20;
  localparam logic [7:0] ADDR_CL_LIM = 8'h24;
  localparam logic [7:0] ADDR_OL_LIM = 8'h28;
  localparam logic [7:0] ADDR_DRIVE = 8'h2c;
  localparam logic [7:0] ADDR_TRAJ_POS = 8'h30;
  localparam logic [7:0] ADDR_TGT_POS = 8'h34;
  localparam logic [7:0] ADDR_TGT_VEL = 8'h38;
  localparam logic [2:0] ADDR_DATA_HI = 3'h2;
  localparam int CMD_RAMP = 0;
  localparam int CMD_FOLLOW = 1;
  localparam int CMD_OVERRIDE = 2;
  localparam int ST_RAMP = 0;
  localparam int ST_VLIMIT = 1;
  localparam int ST_FOLLOW = 2;
  localparam int ST_MOVING = 3;
  localparam int ST_START_PEND = 4;
  localparam int ST_MODE_ERR = 5;
endpackage : servo_follow_pkg

// ---- src/servo_torque_velocity_follow.sv ----
// Servo torque ramp, velocity limiter and interpolated master follow.
// Assumes a Wishbone classic master on clk_i and a loop velocity from same-clock logic.
// Summary of operation
// RL1 - Ramp command raises limit by increment to final
// RL2 - Ramp touches open-loop limit only
// RL3 - One increment added per 120 us tick
// RL4 - Ramp time equals final over increment ticks
// RL5 - Native 20000 means full current
// RL6 - Last step clipped to final value
// RL7 - Limiter caps velocity, moving and holding values
// RL8 - Moving means trajectory active or settling
// RL9 - Trajectory advances regardless of limiter
// RL10 - Status bit 1 set when limiter engages
// RL11 - Gravity offset added after velocity limiter
// RL12 - Host keeps velocity limit at least 455
// RL13 - Position from chosen register, velocity next
// RL14 - Master position linearly interpolated over interval
// RL15 - Remote velocity copied for whole segment
// RL16 - Host feeds register pair at fixed rate
// RL17 - Only mode 0 accepted, others reserved
// RL18 - Cycle count is ticks between updates
// RL19 - Larger count spreads change over more ticks
// RL20 - Follow stays active until override command
// RL21 - Next command released one tick after start
// RL22 - Follow produces no acceleration feedforward
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module servo_torque_velocity_follow
  import servo_follow_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Servo loop.
  input wire logic [15:0] loop_vel_i,
  output logic [15:0] ol_limit_o,
  output logic [31:0] cl_limits_o,
  output logic [17:0] drive_o,
  output logic [15:0] accel_ff_o,
  output logic vel_limited_o,
  // Follow results.
  output logic [31:0] tgt_pos_o,
  output logic [31:0] tgt_vel_o,
  output logic next_cmd_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] ramp_final;
    logic [15:0] ramp_inc;
    logic ramp_busy;
    logic [15:0] ol_limit;
    logic [31:0] cl_limits;
    logic [15:0] vlim_mov;
    logic [15:0] vlim_hold;
    logic [15:0] settle_ticks;
    logic [15:0] settle_cnt;
    logic [15:0] traj_vel;
    logic [31:0] traj_pos;
    logic [15:0] gravity;
    logic [15:0] accel_cfg;
    logic [15:0] accel_ff;
    logic vel_limited;
    logic [17:0] drive;
    logic mode_err;
    logic [15:0] fmode;
    logic [7:0] fcycles;
    logic [2:0] fidx;
    logic follow;
    logic seg_pending;
    logic start_pend;
    logic next_cmd;
    logic [31:0] seg_start;
    logic [32:0] seg_delta;
    logic [7:0] seg_k;
    logic [31:0] tgt_pos;
    logic [31:0] tgt_vel;
    logic [7:0][31:0] data;
    logic [15:0] tick_cnt;
  } state_s;

  state_s q;
  state_s next_q;

  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = cur;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : sext16

  logic tick;
  logic acc_req;
  logic wr_req;
  logic moving;
  logic engaged;
  logic [15:0] vlim;
  logic signed [16:0] vin;
  logic signed [16:0] lim17;
  logic signed [16:0] sat;
  logic [7:0] ncyc;
  logic [31:0] rv;
  logic [31:0] wd;
  logic [16:0] ramp_sum;
  logic [7:0] k_next;
  logic signed [41:0] prod;
  logic [2:0] vidx;

  // The tick counter is wide enough for the default; keep TICK_LEN below 65536.
  assign tick = (q.tick_cnt == 16'(TICK_LEN - 1)); // see RL3
  assign acc_req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wr_req = acc_req & wb_we_i;
  assign moving = q.follow | (q.traj_vel != 16'h0000) | (q.settle_cnt != 16'h0000); // see RL8
  assign vlim = moving ? q.vlim_mov : q.vlim_hold; // see RL7
  assign vin = {loop_vel_i[15], loop_vel_i};
  assign lim17 = {1'b0, vlim};
  assign engaged = (vin > lim17) | (vin < -lim17); // see RL10
  assign sat = (vin > lim17) ? lim17 : ((vin < -lim17) ? -lim17 : vin); // see RL7
  // A zero count would divide by zero, so it behaves as one tick.
  assign ncyc = (q.fcycles == 8'h00) ? 8'h01 : q.fcycles; // see RL18
  assign vidx = q.fidx + 3'h1; // see RL13

  always_comb begin
    next_q = q;
    rv = 32'h0000_0000;
    wd = 32'h0000_0000;
    ramp_sum = 17'h0_0000;
    k_next = q.seg_k;
    prod = 42'h0;
    next_q.ack = acc_req;
    next_q.next_cmd = 1'b0;
    next_q.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;

    // Read mux, also the base for byte-lane merges on writes.
    if (wb_adr_i[7:5] == ADDR_DATA_HI) begin
      rv = q.data[wb_adr_i[4:2]];
    end else begin
      unique case ({wb_adr_i[7:2], 2'b00})
        ADDR_RAMP: rv = {q.ramp_inc, q.ramp_final};
        ADDR_STATUS: rv = {26'h0, q.mode_err, q.start_pend, moving, q.follow,
                           q.vel_limited, q.ramp_busy};
        ADDR_VLIM: rv = {q.vlim_hold, q.vlim_mov};
        ADDR_FOLLOW: rv = {5'h00, q.fidx, q.fcycles, q.fmode};
        ADDR_SETTLE: rv = {16'h0000, q.settle_ticks};
        ADDR_TRAJ_VEL: rv = {16'h0000, q.traj_vel};
        ADDR_GRAVITY: rv = {16'h0000, q.gravity};
        ADDR_ACCEL: rv = {16'h0000, q.accel_cfg};
        ADDR_CL_LIM: rv = q.cl_limits;
        ADDR_OL_LIM: rv = {16'h0000, q.ol_limit};
        ADDR_DRIVE: rv = {{14{q.drive[17]}}, q.drive};
        ADDR_TRAJ_POS: rv = q.traj_pos;
        ADDR_TGT_POS: rv = q.tgt_pos;
        ADDR_TGT_VEL: rv = q.tgt_vel;
        default: rv = 32'h0000_0000;
      endcase
    end
    next_q.rdata = (acc_req & ~wb_we_i) ? rv : 32'h0000_0000;
    wd = merge(rv, wb_dat_i, wb_sel_i);

    // Servo tick work.
    if (tick) begin
      if (q.ramp_busy) begin
        ramp_sum = {1'b0, q.ol_limit} + {1'b0, q.ramp_inc}; // see RL1, RL3, RL4
        if (ramp_sum >= {1'b0, q.ramp_final}) begin
          next_q.ol_limit = q.ramp_final; // see RL6
          next_q.ramp_busy = 1'b0;
        end else begin
          next_q.ol_limit = ramp_sum[15:0]; // see RL2
        end
      end
      // The commanded path keeps integrating even while the motor is clamped.
      next_q.traj_pos = q.traj_pos + sext16(q.traj_vel); // see RL9
      if (q.follow | (q.traj_vel != 16'h0000)) begin
        next_q.settle_cnt = q.settle_ticks;
      end else if (q.settle_cnt != 16'h0000) begin
        next_q.settle_cnt = q.settle_cnt - 16'h0001;
      end
      if (q.start_pend) begin
        next_q.start_pend = 1'b0;
        next_q.next_cmd = 1'b1; // see RL21
      end
      if (q.follow) begin
        if (q.seg_pending) begin
          next_q.seg_pending = 1'b0;
          next_q.seg_start = q.tgt_pos;
          next_q.seg_delta = {q.data[q.fidx][31], q.data[q.fidx]} -
                             {q.tgt_pos[31], q.tgt_pos}; // see RL13
          next_q.tgt_vel = q.data[vidx]; // see RL15
          k_next = 8'h01;
        end else if (q.seg_k < ncyc) begin
          k_next = q.seg_k + 8'h01;
        end
        next_q.seg_k = k_next;
        // Spreading over more ticks smooths the path but adds lag.
        prod = $signed({next_q.seg_delta[32], next_q.seg_delta}) *
               $signed({34'h0, k_next}); // see RL14, RL19
        next_q.tgt_pos = next_q.seg_start + 32'(prod / $signed({34'h0, ncyc}));
      end
    end

    // Register writes.
    if (wr_req) begin
      if (wb_adr_i[7:5] == ADDR_DATA_HI) begin
        next_q.data[wb_adr_i[4:2]] = wd;
        if (wb_adr_i[4:2] == q.fidx) begin
          next_q.seg_pending = 1'b1;
        end
      end else begin
        unique case ({wb_adr_i[7:2], 2'b00})
          ADDR_RAMP: begin
            next_q.ramp_final = {1'b0, wd[14:0]};
            next_q.ramp_inc = (wd[30:16] == 15'h0000) ? RST_RAMP_INC : {1'b0, wd[30:16]};
          end
          ADDR_CMD: begin
            if (wd[CMD_RAMP]) begin
              next_q.ol_limit = 16'h0000; // see RL1
              next_q.ramp_busy = 1'b1;
            end
            if (wd[CMD_FOLLOW]) begin
              if (q.fmode == MODE_ABSOLUTE) begin // see RL17
                next_q.follow = 1'b1;
                next_q.seg_pending = 1'b1;
                next_q.start_pend = 1'b1;
                next_q.mode_err = 1'b0;
                next_q.tgt_pos = q.traj_pos;
              end else begin
                next_q.mode_err = 1'b1;
              end
            end
            if (wd[CMD_OVERRIDE]) begin
              next_q.follow = 1'b0; // see RL20
              next_q.traj_pos = q.tgt_pos;
            end
          end
          ADDR_STATUS: if (wd[ST_VLIMIT]) next_q.vel_limited = 1'b0;
          ADDR_VLIM: begin
            next_q.vlim_mov = {1'b0, wd[14:0]}; // see RL7
            next_q.vlim_hold = {1'b0, wd[30:16]};
          end
          ADDR_FOLLOW: begin
            next_q.fmode = wd[15:0];
            next_q.fcycles = wd[23:16];
            next_q.fidx = wd[26:24];
          end
          ADDR_SETTLE: next_q.settle_ticks = wd[15:0];
          ADDR_TRAJ_VEL: next_q.traj_vel = wd[15:0];
          ADDR_GRAVITY: next_q.gravity = wd[15:0];
          ADDR_ACCEL: next_q.accel_cfg = wd[15:0];
          ADDR_CL_LIM: next_q.cl_limits = wd;
          default: next_q.ack = acc_req;
        endcase
      end
    end

    // The offset is summed after the limiter, so a large one can defeat it.
    next_q.drive = 18'(sat) + {{2{q.gravity[15]}}, q.gravity}; // see RL11
    next_q.accel_ff = next_q.follow ? 16'h0000 : q.accel_cfg; // see RL22
    // A new engagement beats a clear in the same cycle.
    if (engaged) begin
      next_q.vel_limited = 1'b1; // see RL10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ramp_final <= FULL_CURRENT; // see RL5
      q.ramp_inc <= RST_RAMP_INC;
      q.vlim_mov <= RST_VLIM;
      q.vlim_hold <= RST_VLIM;
      q.fcycles <= RST_CYCLES;
      q.fmode <= MODE_ABSOLUTE;
    end else begin
      q <= next_q;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign ol_limit_o = q.ol_limit;
  assign cl_limits_o = q.cl_limits;
  assign drive_o = q.drive;
  assign accel_ff_o = q.accel_ff;
  assign vel_limited_o = q.vel_limited;
  assign tgt_pos_o = q.tgt_pos;
  assign tgt_vel_o = q.tgt_vel;
  assign next_cmd_o = q.next_cmd;

  AST_RAMP_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL1
    tick && q.ramp_busy && !wr_req &&
    ({1'b0, q.ol_limit} + {1'b0, q.ramp_inc} < {1'b0, q.ramp_final})
    |=> q.ol_limit == $past(q.ol_limit) + $past(q.ramp_inc))
    else $error("ramp step wrong");
  AST_RAMP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // see RL3
    !tick && !wr_req |=> $stable(q.ol_limit))
    else $error("open-loop limit moved between ticks");
  AST_RAMP_CLIP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL6
    q.ramp_busy |-> q.ol_limit <= q.ramp_final)
    else $error("ramp passed final value");
  AST_CL_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL2
    !(wr_req && wb_adr_i == ADDR_CL_LIM) |=> $stable(q.cl_limits))
    else $error("closed-loop limits changed");
  AST_VLIM_CAP: assert property (@(posedge clk_i) disable iff (rst_i) // see RL7
    q.gravity == 16'h0000 |=> ($signed(q.drive) <= $signed({2'b00, $past(vlim)})) &&
    ($signed(q.drive) >= -$signed({2'b00, $past(vlim)})))
    else $error("velocity not capped");
  AST_MOVING: assert property (@(posedge clk_i) disable iff (rst_i) // see RL8
    (q.follow || q.settle_cnt != 16'h0000) |-> vlim == q.vlim_mov)
    else $error("holding limit used while moving");
  AST_TRAJ: assert property (@(posedge clk_i) disable iff (rst_i) // see RL9
    tick && !wr_req |=> q.traj_pos == $past(q.traj_pos) + sext16($past(q.traj_vel)))
    else $error("trajectory stalled");
  AST_FLAG: assert property (@(posedge clk_i) disable iff (rst_i) // see RL10
    engaged |=> q.vel_limited)
    else $error("limit flag not set");
  AST_VEL_COPY: assert property (@(posedge clk_i) disable iff (rst_i) // see RL15
    tick && q.follow && q.seg_pending |=> q.tgt_vel == $past(q.data[vidx]))
    else $error("velocity not copied");
  AST_MODE: assert property (@(posedge clk_i) disable iff (rst_i) // see RL17
    wr_req && wb_adr_i == ADDR_CMD && wb_sel_i[0] && wb_dat_i[CMD_FOLLOW] &&
    q.fmode != MODE_ABSOLUTE |=> q.mode_err && !$rose(q.follow))
    else $error("reserved mode accepted");
  AST_NEXT: assert property (@(posedge clk_i) disable iff (rst_i) // see RL21
    tick && q.start_pend |=> next_cmd_o)
    else $error("next command not released");
  AST_NO_FF: assert property (@(posedge clk_i) disable iff (rst_i) // see RL22
    q.follow |-> q.accel_ff == 16'h0000)
    else $error("feedforward during follow");

  COV_RAMP_DONE: cover property (@(posedge clk_i) disable iff (rst_i) $fell(q.ramp_busy));
  COV_SEGMENT: cover property (@(posedge clk_i) disable iff (rst_i)
    q.follow && q.seg_k == ncyc && ncyc > 8'h01);
  COV_ENGAGE: cover property (@(posedge clk_i) disable iff (rst_i) engaged && moving);
endmodule : servo_torque_velocity_follow

// ---- sim/host_link_model.sv ----
// Host command link model: a classic Wishbone master issuing single cycles.
// Assumes a slave on the same clock that answers every request with ack.
`timescale 1ns/1ps
module host_link_model (
  // Clock.
  input wire logic clk_i,
  // Wishbone master side.
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // The request is held until ack is sampled, so a slow slave is waited out.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] w,
                      output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= a;
    wb_sel_o <= 4'hf;
    wb_dat_o <= w;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    r = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_dat_o <= ~w;
  endtask : xfer

  // One master update writes position and velocity as a pair, once per interval.
  task automatic feed(input logic [2:0] idx, input logic [31:0] pos, input logic [31:0] vel);
    logic [31:0] r;
    xfer(1'b1, {3'b010, idx, 2'b00}, pos, r);
    xfer(1'b1, {3'b010, 3'(idx + 3'h1), 2'b00}, vel, r);
  endtask : feed
endmodule : host_link_model

// ---- sim/testbench.sv ----
// Self-checking bench for the servo torque, velocity limit and follow block.
// Assumes the package, the design and the host link model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  import servo_follow_pkg::*;
  localparam int TL = 20;
  localparam int LIMIT = 6000;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r;} reg_row_s;
  logic clk_i, rst_i, cyc, stb, we, ack, vel_limited, next_cmd;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, cl_limits, tgt_pos, tgt_vel, r, p0, p1, d, last;
  logic [15:0] loop_vel, ol_limit, accel_ff;
  logic [17:0] drive;
  int failures = 0, n_compared = 0, cyc_n = 0, pulses, steps, first, i;
  // Vlim row keeps both limits above the motion floor of 455.
  reg_row_s rows [10] = '{'{ADDR_RAMP, 32'h00040009, 32'h00040009},
    '{ADDR_VLIM, 32'h01f403e8, 32'h01f403e8}, '{ADDR_FOLLOW, 32'h02040000, 32'h02040000},
    '{ADDR_SETTLE, 32'h2, 32'h2}, '{ADDR_GRAVITY, 32'h0, 32'h0}, '{ADDR_ACCEL, 32'h7b, 32'h7b},
    '{ADDR_CL_LIM, 32'h12345678, 32'h12345678}, '{ADDR_CMD, 32'h0, 32'h0},
    '{8'h3c, 32'hffffffff, 32'h0}, '{ADDR_DRIVE, 32'hffffffff, 32'h0}};

  host_link_model host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_ack_i(ack), .wb_dat_i(rdat));

  servo_torque_velocity_follow #(.TICK_LEN(TL)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .loop_vel_i(loop_vel),
    .ol_limit_o(ol_limit), .cl_limits_o(cl_limits), .drive_o(drive),
    .accel_ff_o(accel_ff), .vel_limited_o(vel_limited), .tgt_pos_o(tgt_pos),
    .tgt_vel_o(tgt_vel), .next_cmd_o(next_cmd));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // A hang is cut at a ceiling well above the several hundred cycles the run needs.
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT) begin
      failures++;
      final_report();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic vcheck(input logic [15:0] v, input logic [17:0] e, input string nm);
    @(posedge clk_i);
    loop_vel <= v;
    step(3);
    `CHK(nm, e, drive)
  endtask : vcheck

  initial begin
    rst_i = 1'b1;
    loop_vel = 16'h0000;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1);
    `CHK("ol_limit", 16'h0000, ol_limit)
    host.xfer(1'b0, ADDR_RAMP, 32'h0, r);
    `CHK("ramp_rst", {16'h0001, FULL_CURRENT}, r)
    host.xfer(1'b0, ADDR_VLIM, 32'h0, r);
    `CHK("vlim_rst", 32'h7fff7fff, r)
    host.xfer(1'b0, ADDR_FOLLOW, 32'h0, r);
    `CHK("follow_rst", 32'h00010000, r)
    $display("test reset done");
    foreach (rows[k]) begin
      host.xfer(1'b1, rows[k].a, rows[k].w, r);
      host.xfer(1'b0, rows[k].a, 32'h0, r);
      `CHK("readback", rows[k].r, r)
    end
    $display("test registers done");
    host.xfer(1'b1, ADDR_CMD, 32'h1, r);
    for (i = 0; i < 3 * TL && ol_limit !== 16'h0004; i++) step(1);
    `CHK("first_step", 16'h0004, ol_limit)
    step(TL - 1);
    `CHK("before_tick", 16'h0004, ol_limit)
    step(1);
    `CHK("second_step", 16'h0008, ol_limit)
    step(TL);
    `CHK("clipped", 16'h0009, ol_limit)
    step(2 * TL);
    `CHK("settled", 16'h0009, ol_limit)
    `CHK("cl_limits", 32'h12345678, cl_limits)
    $display("test ramp done");
    vcheck(16'h07d0, 18'h001f4, "hold_clamp");
    `CHK("limited", 1'b1, vel_limited)
    vcheck(16'hf830, 18'h3fe0c, "neg_clamp");
    vcheck(16'h012c, 18'h0012c, "pass");
    `CHK("sticky", 1'b1, vel_limited)
    host.xfer(1'b1, ADDR_STATUS, 32'h2, r);
    step(2);
    `CHK("cleared", 1'b0, vel_limited)
    host.xfer(1'b1, ADDR_GRAVITY, 32'h00000fa0, r);
    vcheck(16'h07d0, 18'h01194, "gravity");
    host.xfer(1'b1, ADDR_GRAVITY, 32'h0, r);
    host.xfer(1'b1, ADDR_TRAJ_VEL, 32'h7, r);
    vcheck(16'h07d0, 18'h003e8, "moving");
    host.xfer(1'b0, ADDR_TRAJ_POS, 32'h0, p1);
    step(5 * TL - 3);
    host.xfer(1'b0, ADDR_TRAJ_POS, 32'h0, r);
    `CHK("traj_adv", 32'd35, r - p1)
    host.xfer(1'b1, ADDR_TRAJ_VEL, 32'h0, r);
    step(2);
    `CHK("settling", 18'h003e8, drive)
    step(4 * TL);
    `CHK("holding", 18'h001f4, drive)
    $display("test limiter done");
    `CHK("accel_idle", 16'h007b, accel_ff)
    host.xfer(1'b0, ADDR_TRAJ_POS, 32'h0, p0);
    host.feed(3'h2, p0 + 32'd400, 32'h00000055);
    host.xfer(1'b1, ADDR_CMD, 32'h2, r);
    pulses = 0;
    steps = 0;
    first = 0;
    last = 32'h0;
    for (i = 0; i < 7 * TL; i++) begin
      step(1);
      d = tgt_pos - p0;
      if (next_cmd === 1'b1 && pulses == 0) first = i;
      if (next_cmd === 1'b1) pulses++;
      if (d !== last && d <= 32'd400 && d != 32'd0) begin
        steps++;
        `CHK("step_size", 32'd0, d % 32'd100)
      end
      last = d;
    end
    `CHK("pulses", 1, pulses)
    `CHK("pulse_soon", 1'b1, first < TL)
    `CHK("segments", 4, steps)
    `CHK("tgt_final", p0 + 32'd400, tgt_pos)
    `CHK("tgt_vel", 32'h00000055, tgt_vel)
    `CHK("accel_follow", 16'h0000, accel_ff)
    host.xfer(1'b0, ADDR_STATUS, 32'h0, r);
    `CHK("still_follow", 1'b1, r[ST_FOLLOW])
    host.xfer(1'b1, ADDR_CMD, 32'h4, r);
    step(2);
    `CHK("accel_back", 16'h007b, accel_ff)
    $display("test follow done");
    host.xfer(1'b1, ADDR_FOLLOW, 32'h02040001, r);
    host.xfer(1'b1, ADDR_CMD, 32'h2, r);
    pulses = 0;
    for (i = 0; i < 2 * TL; i++) begin
      step(1);
      if (next_cmd === 1'b1) pulses++;
    end
    `CHK("refused_pulse", 0, pulses)
    host.xfer(1'b0, ADDR_STATUS, 32'h0, r);
    `CHK("mode_err", 2'b10, {r[ST_MODE_ERR], r[ST_FOLLOW]})
    $display("test mode done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    step(1);
    `CHK("rst_ol_limit", 16'h0000, ol_limit)
    `CHK("rst_flag", 1'b0, vel_limited)
    `CHK("rst_drive", 18'h007d0, drive)
    `CHK("rst_tgt_pos", 32'h0, tgt_pos)
    host.xfer(1'b0, ADDR_RAMP, 32'h0, r);
    `CHK("ramp_rst_again", {16'h0001, FULL_CURRENT}, r)
    $display("test reset again done");
    final_report();
  end
endmodule : testbench
